// ### inc/tdf_pkg.sv
/*
  Constants, types and derived cycle counts for the debug frame sender.
  Assumes a 125 MHz system clock and a 48 ns link clock.
*/
// Operation
// - Over-long short: debug, channel 3 unusable
// - Stuck channel 3 recalibrates after max on-time
// - Lines float idle, push-pull while sending
// - Bits near 200 kHz, MSB first
// - Frame index in byte 0, repeated last
// - Byte 1 holds chip version nibbles
// - Bytes 2-9 references, low byte first
// - Bytes 10-17 signals, low byte first
// - Bytes 18-25 signed deltas, low first
// - Bytes 26-27 opaque flag bytes
// - Status bit 7 shows calibration running
// - Status bits 4-6 hold key count
// - Status bits 0-3 show key touches
// - Bytes follow each other at fixed spacing
// - Thirty-byte frame, floating between frames
// - Calibrate at power-up and on triggers
package tdf_pkg;
  // ****************************************
  // Clocks and printed times
  // ****************************************
  localparam longint CLK_HZ = 125_000_000;
  localparam int LINK_PERIOD_NS = 48;
  localparam longint PWRUP_CAL_MS = 50;
  localparam longint SHORT_LIMIT_S = 5;
  localparam longint MAX_ON_S = 30;
  localparam longint CAL_LEN_MS = 1;
  localparam int BIT_RATE_KHZ = 200;
  localparam int BYTE_GAP_NS = 26_000;
  localparam longint PWRUP_CAL_CYC = PWRUP_CAL_MS * CLK_HZ / 1000;
  localparam longint SHORT_LIMIT_CYC = SHORT_LIMIT_S * CLK_HZ;
  localparam longint MAX_ON_CYC = MAX_ON_S * CLK_HZ;
  localparam longint CAL_LEN_CYC = CAL_LEN_MS * CLK_HZ / 1000;
  localparam int STRAP_CYC = 8;
  localparam int BIT_HALF_CYC = 1_000_000 / (2 * BIT_RATE_KHZ * LINK_PERIOD_NS);
  localparam int GAP_CYC = BYTE_GAP_NS / LINK_PERIOD_NS;
  localparam int CNT_W = 10;
  // ****************************************
  // Frame layout
  // ****************************************
  localparam int FRAME_BYTES = 30;
  localparam int VERSION_BYTE = 1;
  localparam int WORD_BASE = 2;
  localparam int WORD_COUNT = 12;
  localparam int FLAG_BYTE = 26;
  localparam int STATUS_BYTE = 28;
  localparam int LAST_BYTE = 29;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_REF01 = 8'h00;
  localparam logic [7:0] ADDR_REF23 = 8'h04;
  localparam logic [7:0] ADDR_SIG01 = 8'h08;
  localparam logic [7:0] ADDR_SIG23 = 8'h0C;
  localparam logic [7:0] ADDR_DLT01 = 8'h10;
  localparam logic [7:0] ADDR_DLT23 = 8'h14;
  localparam logic [7:0] ADDR_KEYS = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam int KEYS_TOUCH_LSB = 16;
  localparam int KEYS_COUNT_LSB = 20;
  localparam int CTRL_BURST_BIT = 0;
  localparam int CTRL_RECAL_BIT = 1;
  localparam logic [2:0] KEY_COUNT_RST = 3'h4;
  localparam logic [7:0] INDEX_RST = 8'h00;
  typedef enum logic [3:0] {
    LK_IDLE = 4'b0001,
    LK_LO = 4'b0010,
    LK_HI = 4'b0100,
    LK_GAP = 4'b1000
  } tdf_link_st_t;
endpackage

// ### core/tdf_frame_sender.sv
/*
  Debug frame sender: APB registers, calibration timing, debug-mode strap,
  and a link-clock shifter for the serial clock and data pins.
  Assumes an APB master on I_CLOCK and a free-running link clock.
*/
`timescale 1ns/10ps
module tdf_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [WIDTH-1:0] i_d,
  output logic [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] s1_r, s2_r, s3_r, q_r, agree;
  // Per bit: accept only once the last two stages agree
  assign agree = ~(s2_r ^ s3_r);
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= (s3_r & agree) | (q_r & ~agree);
    end
  end
  assign o_q = q_r;
endmodule

module tdf_frame_sender #(
  parameter logic [31:0] P_PWRUP_CAL_CYC = 32'(tdf_pkg::PWRUP_CAL_CYC),
  parameter logic [31:0] P_SHORT_LIMIT_CYC = 32'(tdf_pkg::SHORT_LIMIT_CYC),
  parameter logic [31:0] P_MAX_ON_CYC = 32'(tdf_pkg::MAX_ON_CYC),
  parameter logic [31:0] P_CAL_LEN_CYC = 32'(tdf_pkg::CAL_LEN_CYC),
  // Arbitrary value
  parameter logic [7:0] P_CHIP_VERSION = 8'h21
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire logic I_LINK_CLK,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_CHAN3_SAMPLE_CAPACITOR_SHORT,
  output logic O_KEY0_OUT_OR_SERIAL_CLOCK,
  output logic O_KEY0_OUT_OR_SERIAL_CLOCK_OE_B,
  output logic O_KEY1_OUT_OR_SERIAL_DATA,
  output logic O_KEY1_OUT_OR_SERIAL_DATA_OE_B
);
  // ****************************************
  // APB slave and registers
  // ****************************************
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, hit, acc, wr_en;
  logic [31:0] prdata_r, prdata_nxt, rd_word;
  logic [31:0] data_r [0:5];
  logic [31:0] data_nxt [0:5];
  logic [15:0] flags_r, flags_nxt;
  logic [3:0] touch_r, touch_nxt, keys_eff;
  logic [2:0] nkeys_r, nkeys_nxt;
  logic [7:0] index_r, index_nxt;
  logic busy_r, busy_nxt, req_r, req_nxt, ack_seen_r, ack_seen_nxt, ack_s;
  logic ack_r, ack_nxt;
  logic debug_r, debug_nxt, chan3_bad_r, chan3_bad_nxt, cal_busy_r, cal_busy_nxt;
  logic pu_done_r, pu_done_nxt, short_s, start, burst, recal_req;
  logic pu_hit, short_hit, maxon_hit, cal_start, any_on;
  logic [31:0] pu_cnt_r, pu_cnt_nxt, short_cnt_r, short_cnt_nxt;
  logic [31:0] maxon_cnt_r, maxon_cnt_nxt, cal_cnt_r, cal_cnt_nxt;
  logic [7:0] frame_r [0:tdf_pkg::FRAME_BYTES-1];
  logic [7:0] frame_nxt [0:tdf_pkg::FRAME_BYTES-1];

  // One wait state: answer in the second access cycle
  assign acc = I_PSEL & I_PENABLE & ~pready_r;
  assign wr_en = I_PSEL & I_PENABLE & pready_r & I_PWRITE & hit;
  assign burst = wr_en & (I_PADDR == tdf_pkg::ADDR_CTRL) & I_PWDATA[tdf_pkg::CTRL_BURST_BIT];
  assign recal_req = wr_en & (I_PADDR == tdf_pkg::ADDR_CTRL)
                     & I_PWDATA[tdf_pkg::CTRL_RECAL_BIT];
  assign keys_eff = {touch_r[3] | chan3_bad_r, touch_r[2:0]};
  assign start = burst & debug_r & ~busy_r;

  always_comb begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    case (I_PADDR)
      tdf_pkg::ADDR_REF01, tdf_pkg::ADDR_REF23, tdf_pkg::ADDR_SIG01,
      tdf_pkg::ADDR_SIG23, tdf_pkg::ADDR_DLT01, tdf_pkg::ADDR_DLT23: begin
        rd_word = data_r[I_PADDR[4:2]];
      end
      tdf_pkg::ADDR_KEYS: begin
        rd_word = {9'h000, nkeys_r, touch_r, flags_r};
      end
      tdf_pkg::ADDR_CTRL: begin
        rd_word = 32'h0000_0000;
      end
      tdf_pkg::ADDR_STATUS: begin
        rd_word = {16'h0000, index_r, 3'h0, pu_done_r, busy_r, cal_busy_r,
                   chan3_bad_r, debug_r};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    pready_nxt = acc;
    prdata_nxt = (acc & ~I_PWRITE) ? rd_word : 32'h0000_0000;
    pslverr_nxt = acc & ~hit;
    data_nxt = data_r;
    flags_nxt = flags_r;
    touch_nxt = touch_r;
    nkeys_nxt = nkeys_r;
    if (wr_en && I_PADDR < tdf_pkg::ADDR_KEYS) begin
      data_nxt[I_PADDR[4:2]] = I_PWDATA;
    end
    if (wr_en && I_PADDR == tdf_pkg::ADDR_KEYS) begin
      flags_nxt = I_PWDATA[15:0];
      touch_nxt = I_PWDATA[tdf_pkg::KEYS_TOUCH_LSB +: 4];
      nkeys_nxt = I_PWDATA[tdf_pkg::KEYS_COUNT_LSB +: 3];
    end
  end

  // ****************************************
  // Frame snapshot and handshake
  // ****************************************
  // Snapshot stays frozen until the link acknowledges, so it can cross as words
  always_comb begin
    frame_nxt = frame_r;
    index_nxt = index_r;
    req_nxt = req_r;
    busy_nxt = busy_r;
    ack_seen_nxt = ack_seen_r;
    if (ack_s != ack_seen_r) begin
      ack_seen_nxt = ack_s;
      busy_nxt = 1'b0;
    end
    if (start) begin
      frame_nxt[0] = index_r;
      frame_nxt[tdf_pkg::VERSION_BYTE] = P_CHIP_VERSION;
      for (int k = 0; k < tdf_pkg::WORD_COUNT; k++) begin
        frame_nxt[tdf_pkg::WORD_BASE + 2 * k] = data_r[k / 2][16 * (k % 2) +: 8];
        frame_nxt[tdf_pkg::WORD_BASE + 2 * k + 1] = data_r[k / 2][16 * (k % 2) + 8 +: 8];
      end
      frame_nxt[tdf_pkg::FLAG_BYTE] = flags_r[7:0];
      frame_nxt[tdf_pkg::FLAG_BYTE + 1] = flags_r[15:8];
      frame_nxt[tdf_pkg::STATUS_BYTE] = {cal_busy_r, nkeys_r, keys_eff};
      frame_nxt[tdf_pkg::LAST_BYTE] = index_r;
      index_nxt = 8'(index_r + 8'h01);
      req_nxt = ~req_r;
      busy_nxt = 1'b1;
    end
  end

  // ****************************************
  // Strap, calibration and max on-time
  // ****************************************
  assign any_on = |keys_eff;
  assign pu_hit = ~pu_done_r & (pu_cnt_r == P_PWRUP_CAL_CYC - 32'h0000_0001);
  assign short_hit = debug_r & short_s & (short_cnt_r == P_SHORT_LIMIT_CYC - 32'h0000_0001);
  assign maxon_hit = any_on & ~cal_busy_r & (maxon_cnt_r == P_MAX_ON_CYC - 32'h0000_0001);
  assign cal_start = pu_hit | maxon_hit | recal_req;

  always_comb begin
    pu_cnt_nxt = pu_done_r ? pu_cnt_r : 32'(pu_cnt_r + 32'h0000_0001);
    pu_done_nxt = pu_done_r | pu_hit;
    debug_nxt = debug_r;
    // strap caught once the filter has settled
    if (pu_cnt_r == 32'(tdf_pkg::STRAP_CYC)) begin
      debug_nxt = short_s;
    end
    short_cnt_nxt = short_cnt_r;
    if (debug_r && short_s && short_cnt_r != P_SHORT_LIMIT_CYC) begin
      short_cnt_nxt = 32'(short_cnt_r + 32'h0000_0001);
    end
    maxon_cnt_nxt = 32'h0000_0000;
    if (any_on && !cal_busy_r && !maxon_hit) begin
      maxon_cnt_nxt = 32'(maxon_cnt_r + 32'h0000_0001);
    end
    cal_busy_nxt = cal_busy_r;
    cal_cnt_nxt = 32'(cal_cnt_r + 32'h0000_0001);
    chan3_bad_nxt = chan3_bad_r;
    if (cal_busy_r && cal_cnt_r == P_CAL_LEN_CYC - 32'h0000_0001) begin
      cal_busy_nxt = 1'b0;
      chan3_bad_nxt = 1'b0;
    end
    if (cal_start) begin
      cal_busy_nxt = 1'b1;
      cal_cnt_nxt = 32'h0000_0000;
    end
    if (short_hit) begin
      chan3_bad_nxt = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      data_r <= '{default: 32'h0000_0000};
      flags_r <= 16'h0000;
      touch_r <= 4'h0;
      nkeys_r <= tdf_pkg::KEY_COUNT_RST;
      frame_r <= '{default: 8'h00};
      index_r <= tdf_pkg::INDEX_RST;
      req_r <= 1'b0;
      busy_r <= 1'b0;
      ack_seen_r <= 1'b0;
      pu_cnt_r <= 32'h0000_0000;
      pu_done_r <= 1'b0;
      debug_r <= 1'b0;
      short_cnt_r <= 32'h0000_0000;
      maxon_cnt_r <= 32'h0000_0000;
      cal_busy_r <= 1'b0;
      cal_cnt_r <= 32'h0000_0000;
      chan3_bad_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      data_r <= data_nxt;
      flags_r <= flags_nxt;
      touch_r <= touch_nxt;
      nkeys_r <= nkeys_nxt;
      frame_r <= frame_nxt;
      index_r <= index_nxt;
      req_r <= req_nxt;
      busy_r <= busy_nxt;
      ack_seen_r <= ack_seen_nxt;
      pu_cnt_r <= pu_cnt_nxt;
      pu_done_r <= pu_done_nxt;
      debug_r <= debug_nxt;
      short_cnt_r <= short_cnt_nxt;
      maxon_cnt_r <= maxon_cnt_nxt;
      cal_busy_r <= cal_busy_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      chan3_bad_r <= chan3_bad_nxt;
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;

  tdf_sync3 #(.WIDTH(1)) u_short_sync (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_d(I_CHAN3_SAMPLE_CAPACITOR_SHORT),
    .o_q(short_s)
  );
  tdf_sync3 #(.WIDTH(1)) u_ack_sync (
    .i_clk(I_CLOCK),
    .i_rst_b(I_RST_B),
    .i_d(ack_r),
    .o_q(ack_s)
  );

  // ****************************************
  // Link domain shifter
  // ****************************************
  logic lrst1_r, link_rst_b;
  logic req_s, racc_r, racc_nxt;
  logic [tdf_pkg::CNT_W-1:0] hi_cnt_r, hi_cnt_nxt;
  logic [2:0] mode_s;
  tdf_pkg::tdf_link_st_t st_r, st_nxt;
  logic [tdf_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [4:0] byte_r, byte_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic sclk_r, sclk_nxt, sdat_r, sdat_nxt, drive;
  logic clk_oe_b_r, clk_oe_b_nxt, dat_oe_b_r, dat_oe_b_nxt;
  logic half_end, gap_end;

  // Reset leaves the link domain only on a link-clock edge
  always_ff @(posedge I_LINK_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      lrst1_r <= 1'b0;
      link_rst_b <= 1'b0;
    end else begin
      lrst1_r <= 1'b1;
      link_rst_b <= lrst1_r;
    end
  end

  tdf_sync3 #(.WIDTH(1)) u_req_sync (
    .i_clk(I_LINK_CLK),
    .i_rst_b(link_rst_b),
    .i_d(req_r),
    .o_q(req_s)
  );
  tdf_sync3 #(.WIDTH(3)) u_mode_sync (
    .i_clk(I_LINK_CLK),
    .i_rst_b(link_rst_b),
    .i_d({debug_r, keys_eff[1:0]}),
    .o_q(mode_s)
  );

  assign half_end = cnt_r == tdf_pkg::CNT_W'(tdf_pkg::BIT_HALF_CYC - 1);
  assign gap_end = cnt_r == tdf_pkg::CNT_W'(tdf_pkg::GAP_CYC - 1);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = tdf_pkg::CNT_W'(cnt_r + 1'b1);
    bit_nxt = bit_r;
    byte_nxt = byte_r;
    sh_nxt = sh_r;
    sclk_nxt = sclk_r;
    sdat_nxt = sdat_r;
    racc_nxt = racc_r;
    ack_nxt = ack_r;
    drive = 1'b1;
    case (st_r)
      tdf_pkg::LK_IDLE: begin
        drive = 1'b0;
        sclk_nxt = 1'b0;
        sdat_nxt = 1'b0;
        cnt_nxt = '0;
        if (req_s != racc_r) begin
          racc_nxt = req_s;
          drive = 1'b1;
          byte_nxt = 5'h00;
          bit_nxt = 3'h0;
          sh_nxt = frame_r[0];
          sdat_nxt = frame_r[0][7];
          st_nxt = tdf_pkg::LK_LO;
        end
      end
      tdf_pkg::LK_LO: begin
        if (half_end) begin
          sclk_nxt = 1'b1;
          cnt_nxt = '0;
          st_nxt = tdf_pkg::LK_HI;
        end
      end
      tdf_pkg::LK_HI: begin
        if (cnt_r == '0 && bit_r != 3'h7) begin
          sh_nxt = {sh_r[6:0], 1'b0};
          sdat_nxt = sh_r[6];
        end
        // next MSB early, never while clock low
        if (cnt_r == '0 && bit_r == 3'h7 && byte_r != 5'(tdf_pkg::LAST_BYTE)) begin
          sh_nxt = frame_r[5'(byte_r + 5'h01)];
          sdat_nxt = frame_r[5'(byte_r + 5'h01)][7];
        end
        if (half_end) begin
          sclk_nxt = 1'b0;
          cnt_nxt = '0;
          bit_nxt = 3'(bit_r + 3'h1);
          st_nxt = (bit_r == 3'h7) ? tdf_pkg::LK_GAP : tdf_pkg::LK_LO;
        end
      end
      tdf_pkg::LK_GAP: begin
        if (gap_end) begin
          cnt_nxt = '0;
          if (byte_r == 5'(tdf_pkg::LAST_BYTE)) begin
            drive = 1'b0;
            ack_nxt = ~ack_r;
            sdat_nxt = 1'b0;
            st_nxt = tdf_pkg::LK_IDLE;
          end else begin
            byte_nxt = 5'(byte_r + 5'h01);
            st_nxt = tdf_pkg::LK_LO;
          end
        end
      end
      default: begin
        drive = 1'b0;
        st_nxt = tdf_pkg::LK_IDLE;
      end
    endcase
    clk_oe_b_nxt = drive ? 1'b0 : (mode_s[2] | ~mode_s[0]);
    dat_oe_b_nxt = drive ? 1'b0 : (mode_s[2] | ~mode_s[1]);
    // High-phase length, checked below
    hi_cnt_nxt = sclk_r ? tdf_pkg::CNT_W'(hi_cnt_r + 1'b1) : '0;
  end

  always_ff @(posedge I_LINK_CLK or negedge link_rst_b) begin
    if (!link_rst_b) begin
      st_r <= tdf_pkg::LK_IDLE;
      cnt_r <= '0;
      bit_r <= 3'h0;
      byte_r <= 5'h00;
      sh_r <= 8'h00;
      sclk_r <= 1'b0;
      sdat_r <= 1'b0;
      racc_r <= 1'b0;
      ack_r <= 1'b0;
      clk_oe_b_r <= 1'b1;
      dat_oe_b_r <= 1'b1;
      hi_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      byte_r <= byte_nxt;
      sh_r <= sh_nxt;
      sclk_r <= sclk_nxt;
      sdat_r <= sdat_nxt;
      racc_r <= racc_nxt;
      ack_r <= ack_nxt;
      clk_oe_b_r <= clk_oe_b_nxt;
      dat_oe_b_r <= dat_oe_b_nxt;
      hi_cnt_r <= hi_cnt_nxt;
    end
  end

  // Normal mode: open-drain active-low key outputs, pin level stays 0
  assign O_KEY0_OUT_OR_SERIAL_CLOCK = sclk_r;
  assign O_KEY0_OUT_OR_SERIAL_CLOCK_OE_B = clk_oe_b_r;
  assign O_KEY1_OUT_OR_SERIAL_DATA = sdat_r;
  assign O_KEY1_OUT_OR_SERIAL_DATA_OE_B = dat_oe_b_r;

  // ****************************************
  // Checks
  // ****************************************
  a_sending_driven: assert property (@(posedge I_LINK_CLK) disable iff (!link_rst_b)
    (st_r != tdf_pkg::LK_IDLE) |-> (!clk_oe_b_r && !dat_oe_b_r))
    else $error("debug lines not driven in frame");
  a_idle_floats: assert property (@(posedge I_LINK_CLK) disable iff (!link_rst_b)
    (st_r == tdf_pkg::LK_GAP && byte_r == 5'd29 && gap_end) |=> (clk_oe_b_r && dat_oe_b_r)
    ##1 (clk_oe_b_r && dat_oe_b_r))
    else $error("debug lines not floating after frame");
  a_high_half: assert property (@(posedge I_LINK_CLK) disable iff (!link_rst_b)
    $fell(sclk_r) |-> hi_cnt_r == tdf_pkg::CNT_W'(tdf_pkg::BIT_HALF_CYC))
    else $error("serial clock high phase wrong");
  a_low_stable: assert property (@(posedge I_LINK_CLK) disable iff (!link_rst_b)
    (!sclk_r && $past(!sclk_r) && st_r == tdf_pkg::LK_LO && $past(st_r) == tdf_pkg::LK_LO)
    |-> $stable(sdat_r))
    else $error("data moved while clock low");
  a_index_repeat: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    start |=> (frame_r[0] == $past(index_r) && frame_r[29] == frame_r[0]
    && index_r == 8'($past(index_r) + 8'h01)))
    else $error("frame index bytes wrong");
  a_word_order: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    start |=> (frame_r[2] == $past(data_r[0][7:0]) && frame_r[9] == $past(data_r[1][31:24])
    && frame_r[1] == P_CHIP_VERSION))
    else $error("reference bytes misplaced");
  a_delta_order: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    start |=> (frame_r[18] == $past(data_r[4][7:0]) && frame_r[25] == $past(data_r[5][31:24])))
    else $error("delta bytes misplaced");
  a_status_byte: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    start |=> frame_r[28] == {$past(cal_busy_r), $past(nkeys_r), $past(keys_eff)})
    else $error("status byte wrong");
  a_pwrup_cal: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    pu_hit |=> (cal_busy_r && cal_cnt_r == 32'h0000_0000 && pu_done_r))
    else $error("power-up calibration missed");
  a_maxon_recal: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    maxon_hit |=> (cal_busy_r && maxon_cnt_r == 32'h0000_0000))
    else $error("max on-time recalibration missed");
  a_chan3_stuck: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    short_hit |=> (chan3_bad_r && keys_eff[3]))
    else $error("channel 3 not marked unusable");
  a_apb_wait: assert property (@(posedge I_CLOCK) disable iff (!I_RST_B)
    acc |=> (O_PREADY ##1 !O_PREADY))
    else $error("apb answer timing wrong");
  c_frame_done: cover property (@(posedge I_LINK_CLK) disable iff (!link_rst_b)
    st_r == tdf_pkg::LK_GAP && byte_r == 5'd29 && gap_end);
  c_debug_entry: cover property (@(posedge I_CLOCK) disable iff (!I_RST_B) $rose(debug_r));
  c_chan3_bad: cover property (@(posedge I_CLOCK) disable iff (!I_RST_B) short_hit);
  c_recal: cover property (@(posedge I_CLOCK) disable iff (!I_RST_B) maxon_hit);
endmodule

// ### testbench/tdf_debug_receiver.sv
/*
  Receiver model for the debug clock and data lines.
  Assumes pull-ups on both lines; samples data on rising debug clock.
*/
`timescale 1ns/10ps
module tdf_debug_receiver (
  input wire logic i_sck,
  input wire logic i_sck_oe_b,
  input wire logic i_sda,
  input wire logic i_sda_oe_b,
  output logic [7:0] o_bytes [0:29],
  output int o_count,
  output int o_glitch
);
  logic sck;
  logic sda;
  logic held;
  logic [7:0] sh;
  int nbit;
  // ****************************************
  // Line resolution and capture
  // ****************************************
  // Released lines sit at the pull-up level
  assign sck = i_sck_oe_b ? 1'b1 : i_sck;
  assign sda = i_sda_oe_b ? 1'b1 : i_sda;
  initial begin
    o_count = 0;
    o_glitch = 0;
    nbit = 0;
    sh = 8'h00;
    held = 1'b0;
  end
  always @(negedge sck) begin
    #1 held = sda;
  end
  // Sample on rise, MSB first
  // Rise from release to the pull-up carries no bit
  always @(posedge sck) begin
    if (i_sck_oe_b === 1'b0) begin
      if (sda !== held) begin
        o_glitch++;
      end
      sh = {sh[6:0], sda};
      nbit++;
      if (nbit == 8) begin
        nbit = 0;
        if (o_count < 30) begin
          o_bytes[o_count] = sh;
        end
        o_count++;
      end
    end
  end
endmodule

// ### testbench/tb_tdf_frame_sender.sv
/*
  Testbench for the debug frame sender: APB tasks and frame checks.
  Assumes the receiver model and short calibration parameters.
*/
`timescale 1ns/10ps
module tb_tdf_frame_sender;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_b;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic short_pin;
  logic sck;
  logic sck_oe_b;
  logic sda;
  logic sda_oe_b;
  logic [7:0] rx [0:29];
  int rx_n;
  int rx_glitch;
  int err_total = 0;
  int compares = 0;
  logic [15:0] w [0:11] = '{16'h0001, 16'hFFFF, 16'h1234, 16'h8000, 16'h00FF, 16'hFF00,
    16'h5AA5, 16'h0100, 16'h8000, 16'h7FFF, 16'hFFFE, 16'h0002};
  logic [7:0] ex [0:29];
  logic [31:0] q;
  logic e;
  int i;
  // ****************************************
  // Clocks, design and receiver
  // ****************************************
  always #4 clk = ~clk;
  // Odd offset keeps link clock edges off the system clock edges
  initial begin
    #3;
    forever #24 lclk = ~lclk;
  end
  tdf_frame_sender #(
    .P_PWRUP_CAL_CYC(32'h0000_0064),
    .P_SHORT_LIMIT_CYC(32'h0000_012C),
    .P_MAX_ON_CYC(32'h0000_01F4),
    .P_CAL_LEN_CYC(32'h0000_0032),
    .P_CHIP_VERSION(8'h4B)
  ) u_tdf_frame_sender (
    .I_CLOCK(clk), .I_RST_B(rst_b), .I_LINK_CLK(lclk), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_CHAN3_SAMPLE_CAPACITOR_SHORT(short_pin),
    .O_KEY0_OUT_OR_SERIAL_CLOCK(sck), .O_KEY0_OUT_OR_SERIAL_CLOCK_OE_B(sck_oe_b),
    .O_KEY1_OUT_OR_SERIAL_DATA(sda), .O_KEY1_OUT_OR_SERIAL_DATA_OE_B(sda_oe_b)
  );
  tdf_debug_receiver u_tdf_debug_receiver (
    .i_sck(sck), .i_sck_oe_b(sck_oe_b), .i_sda(sda), .i_sda_oe_b(sda_oe_b),
    .o_bytes(rx), .o_count(rx_n), .o_glitch(rx_glitch)
  );
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait on one status bit
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, tdf_pkg::ADDR_STATUS, 32'h0000_0000);
      n++;
    end while (q[b] !== v && n < 2000);
    chk("status_bit", 32'(v), 32'(q[b]));
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************************************
  // Tests
  // ****************************************
  // Frame of 2 ms plus setup
  initial begin
    #3_000_000;
    err_total++;
    report_and_stop;
  end
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rst_b = 1'b0;
    short_pin = 1'b1;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (400) @(posedge clk);
    short_pin <= 1'b0;
    apb(1'b0, tdf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status_mode", 32'h0000_0013, q & 32'h0000_0013);
    chk("idle_lines", 32'h0000_0003, {sck_oe_b, sda_oe_b});
    poll(1, 1'b0);
    $display("test strap done");
    for (i = 0; i < 6; i++) apb(1'b1, 8'(4 * i), {w[2 * i + 1], w[2 * i]});
    apb(1'b1, tdf_pkg::ADDR_KEYS, 32'h0035_A53C);
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk("word_reg", {w[2 * i + 1], w[2 * i]}, q);
    end
    apb(1'b0, tdf_pkg::ADDR_CTRL, 32'h0000_0000);
    chk("ctrl_read", 32'h0000_0000, q);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped_err", 32'h0000_0001, 32'(e));
    chk("unmapped_data", 32'h0000_0000, q);
    $display("test registers done");
    // Start right after a calibration so none runs mid-snapshot
    poll(2, 1'b1);
    poll(2, 1'b0);
    apb(1'b1, tdf_pkg::ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, tdf_pkg::ADDR_CTRL, 32'h0000_0001);
    i = 0;
    while (rx_n < 30 && i < 300000) begin
      @(posedge clk);
      i++;
    end
    poll(3, 1'b0);
    ex[0] = 8'h00;
    ex[1] = 8'h4B;
    for (i = 0; i < 12; i++) begin
      ex[2 + 2 * i] = w[i][7:0];
      ex[3 + 2 * i] = w[i][15:8];
    end
    ex[26] = 8'h3C;
    ex[27] = 8'hA5;
    ex[28] = 8'h35;
    ex[29] = 8'h00;
    for (i = 0; i < 30; i++) chk("frame_byte", ex[i], rx[i]);
    chk("byte_count", 32'd30, rx_n);
    chk("glitches", 32'd0, rx_glitch);
    chk("idle_after", 32'h0000_0003, {sck_oe_b, sda_oe_b});
    apb(1'b0, tdf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("next_index", 32'h0000_0001, q[15:8]);
    $display("test frame done");
    poll(2, 1'b1);
    poll(2, 1'b0);
    apb(1'b1, tdf_pkg::ADDR_CTRL, 32'h0000_0002);
    apb(1'b0, tdf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("recal_busy", 32'h0000_0004, q & 32'h0000_000C);
    $display("test recal done");
    // Second reset without the short: plain key outputs
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    apb(1'b1, tdf_pkg::ADDR_KEYS, 32'h0001_0000);
    apb(1'b1, tdf_pkg::ADDR_CTRL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    apb(1'b0, tdf_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("plain_status", 32'h0000_0000, q & 32'h0000_000B);
    chk("plain_lines", 32'h0000_0001, {sck_oe_b, sda_oe_b});
    chk("plain_bytes", 32'd30, rx_n);
    $display("test plain mode done");
    report_and_stop;
  end
endmodule
